// ===== common/cps_map.vh
// Constants for the configuration pin sequencer: sync bit positions,
// load modes, timing figures and derived cycle counts.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

// System clock rate in MHz.
`define CPS_CLK_MHZ 40
// Extra wait in the clock-generating mode, least and most, in ns.
`define CPS_WAIT_MIN_NS 30000
`define CPS_WAIT_MAX_NS 300000
// Least wait rounded up to whole cycles.
`define CPS_WAIT_CYCLES ((`CPS_WAIT_MIN_NS * `CPS_CLK_MHZ + 999) / 1000)
// Power stabilisation and one clear pass, in cycles.
`define CPS_STAB_CYCLES 11'h020
`define CPS_CLEAR_CYCLES 11'h010
// Bytes that make up this device's own configuration.
`define CPS_LOAD_BYTES 8'h10
// Divider count at which the generated load clock toggles; the half period is eight cycles.
`define CPS_DIV_HALF 3'h7

// Load mode select codes.
`define CPS_MODE_MASTER 2'h0
`define CPS_MODE_BYTE 2'h2
`define CPS_MODE_SLAVE 2'h3

// Bit positions in the synchroniser vector.
`define CPS_SY_W 17
`define CPS_SY_LCLK 0
`define CPS_SY_SDIN 1
`define CPS_SY_CHSEL 2
`define CPS_SY_CW 3
`define CPS_SY_DONE 4
`define CPS_SY_M0 5
`define CPS_SY_M1 6
`define CPS_SY_SLEEPN 7
`define CPS_SY_RECFGN 8
`define CPS_SY_BUS 9
// Reset value of the synchroniser: the sleep and reconfigure request pins idle high.
`define CPS_SY_RST 17'h0_0180

`endif

// ===== src/cps_sync.v
// Two flip-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is a level; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module cps_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// Clock and reset.
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Levels in and out.
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					meta_q <= RST_VAL[g];
					sync_q <= RST_VAL[g];
				end else begin
					meta_q <= async_i[g];
					sync_q <= meta_q;
				end
			end
			assign sync_o[g] = sync_q;
		end
	endgenerate

endmodule // cps_sync

`default_nettype wire

// ===== src/cps_top.v
// Configuration pin sequencer: power-down, clear, wait, mode sample,
// serial or byte loading with chain forwarding, and I/O activation.
// Assumes pins arrive asynchronously and a 40 MHz system clock.
//
// Functional notes
// - Power-down disables I/O, resets flip-flops.
// - Inputs read Low during power-down.
// - Power-down keeps the stored configuration.
// - Power-down during load restarts configuration.
// - On wake enable inputs first, outputs after.
// - High flag driven High until I/O active.
// - Low flag driven Low until I/O active.
// - Clear/wait held Low during stabilise and clear.
// - External Low on clear/wait holds wait.
// - Clock-generating mode waits 30 us extra.
// - Clear/wait Low flags a load data error.
// - Serial data sampled on load clock rise.
// - Serial out changes on fall, 1.5 periods later.
// - Byte mode loads eight parallel data pins.
// - Chain select enables byte-mode participation.
// - Byte mode serial out enables next device.
// - User pins pulled High before completion.
// - Reconfigure release: finish clear, one more.
// - Mode select sampled after clear/wait High.
// - Completion output released when configuration ends.
`timescale 1ns/1ps
`default_nettype none
`include "cps_map.vh"

module cps_top (
	// Clock and reset.
	input wire sys_clk_i,
	input wire sys_rst_i,
	// Control pins.
	input wire sleep_request_n_i,
	input wire reconfig_n_i,
	input wire [1:0] load_mode_select_i,
	// Open-drain clear/wait indicator.
	input wire clear_wait_i,
	output wire clear_wait_o,
	output reg clear_wait_oe_o,
	// Open-drain completion indicator.
	input wire load_complete_i,
	output wire load_complete_o,
	output reg load_complete_oe_o,
	// Load clock pin.
	input wire load_clock_i,
	output reg load_clock_o,
	output reg load_clock_oe_o,
	// Configuration data pins.
	input wire ser_data_i,
	input wire chain_select_i,
	input wire [7:0] byte_load_bus_i,
	output reg ser_out_o,
	// Status flag pins.
	output reg cfg_active_high_flag_o,
	output reg cfg_active_low_flag_o,
	// User logic side.
	input wire user_flag_hi_i,
	input wire user_flag_lo_i,
	output reg user_in_en_o,
	output reg user_out_en_o,
	output reg user_pullup_o,
	// Configuration memory side.
	input wire cfg_error_i,
	output reg [7:0] cfg_word_o,
	output reg cfg_word_valid_o,
	output reg cfg_mem_clear_o,
	output reg cfg_valid_o
);

	localparam [7:0] ST_STAB = 8'h01;
	localparam [7:0] ST_CLEAR = 8'h02;
	localparam [7:0] ST_WAIT = 8'h04;
	localparam [7:0] ST_MODE = 8'h08;
	localparam [7:0] ST_DELAY = 8'h10;
	localparam [7:0] ST_LOAD = 8'h20;
	localparam [7:0] ST_START = 8'h40;
	localparam [7:0] ST_USER = 8'h80;
	localparam [31:0] WAIT_FULL = `CPS_WAIT_CYCLES;
	localparam [10:0] WAIT_CYC = WAIT_FULL[10:0];

	// Open-drain pins only ever pull Low.
	assign clear_wait_o = 1'b0;
	assign load_complete_o = 1'b0;

	reg [7:0] state_q, state_d;
	reg [10:0] cnt_q, cnt_d;
	reg [1:0] mode_q, mode_d;
	reg extra_q, extra_d;
	reg error_q, error_d;
	reg in_phase_q, in_phase_d;
	reg gen_clk_q;
	reg [2:0] div_q;
	reg lclk_prev_q;
	reg [7:0] sh_q;
	reg [2:0] bitcnt_q;
	reg [7:0] bytes_q;
	reg fwd1_q, fwd0_q;
	reg share_done_q;

	wire [`CPS_SY_W-1:0] sy_raw;
	wire [`CPS_SY_W-1:0] sy;
	wire sleep;
	wire master;
	wire lclk_src;
	wire lclk_rise;
	wire lclk_fall;
	wire loading;
	wire last_byte;

	function is_master;
		input [1:0] m;
		begin
			is_master = (m == `CPS_MODE_MASTER);
		end
	endfunction

	assign master = is_master(mode_q);
	// The generated clock is looped through the same synchroniser so that
	// data and clock keep the same latency in every mode.
	assign lclk_src = master ? gen_clk_q : load_clock_i;

	cps_sync #(
		.W(`CPS_SY_W),
		.RST_VAL(`CPS_SY_RST)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({byte_load_bus_i, reconfig_n_i, sleep_request_n_i,
			load_mode_select_i, load_complete_i, clear_wait_i,
			chain_select_i, ser_data_i, lclk_src}),
		.sync_o(sy_raw)
	);

	assign sleep = ~sy_raw[`CPS_SY_SLEEPN];
	// Every pin but the sleep request itself reads Low while asleep.
	assign sy = sleep ? {`CPS_SY_W{1'b0}} : sy_raw;

	assign loading = (state_q == ST_LOAD) && !error_q;
	assign lclk_rise = loading && sy[`CPS_SY_LCLK] && !lclk_prev_q;
	assign lclk_fall = loading && !sy[`CPS_SY_LCLK] && lclk_prev_q;
	assign last_byte = (bytes_q == `CPS_LOAD_BYTES - 8'h01);

	// Sequencing of the configuration flow.
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		mode_d = mode_q;
		extra_d = extra_q;
		error_d = error_q;
		in_phase_d = in_phase_q;
		case (state_q)
		ST_STAB: begin
			cnt_d = cnt_q + 11'h001;
			if (cnt_q == `CPS_STAB_CYCLES) begin
				state_d = ST_CLEAR;
				cnt_d = 11'h000;
			end
		end
		ST_CLEAR: begin
			cnt_d = cnt_q + 11'h001;
			if (cnt_q == `CPS_CLEAR_CYCLES) begin
				cnt_d = 11'h000;
				// One pass always finishes; a release then earns one more.
				if (!sy[`CPS_SY_RECFGN]) begin
					extra_d = 1'b1;
				end else if (extra_q) begin
					extra_d = 1'b0;
				end else begin
					state_d = ST_WAIT;
				end
			end
		end
		ST_WAIT: begin
			if (sy[`CPS_SY_CW]) begin
				state_d = ST_MODE;
			end
		end
		ST_MODE: begin
			mode_d = {sy[`CPS_SY_M1], sy[`CPS_SY_M0]};
			cnt_d = 11'h000;
			if (is_master({sy[`CPS_SY_M1], sy[`CPS_SY_M0]})) begin
				state_d = ST_DELAY;
			end else begin
				state_d = ST_LOAD;
			end
		end
		ST_DELAY: begin
			cnt_d = cnt_q + 11'h001;
			if (cnt_q == WAIT_CYC - 11'h001) begin
				state_d = ST_LOAD;
			end
		end
		ST_LOAD: begin
			if (cfg_error_i) begin
				error_d = 1'b1;
			end
			// The pulse of the sixteenth word closes this device's share.
			if (!error_q && last_byte && cfg_word_valid_o) begin
				state_d = ST_START;
				in_phase_d = 1'b0;
			end
		end
		ST_START: begin
			// A Low held on the completion pin delays activation.
			if (sy[`CPS_SY_DONE]) begin
				if (!in_phase_q) begin
					in_phase_d = 1'b1;
				end else begin
					state_d = ST_USER;
				end
			end
		end
		ST_USER: begin
			state_d = ST_USER;
		end
		default: begin
			state_d = ST_STAB;
			cnt_d = 11'h000;
		end
		endcase
		// Reconfigure request from any state after stabilisation and clear.
		if (!sy[`CPS_SY_RECFGN] && state_q != ST_STAB &&
				state_q != ST_CLEAR) begin
			state_d = ST_CLEAR;
			cnt_d = 11'h000;
			extra_d = 1'b1;
			error_d = 1'b0;
		end
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_STAB;
			cnt_q <= 11'h000;
			mode_q <= `CPS_MODE_SLAVE;
			extra_q <= 1'b0;
			error_q <= 1'b0;
			in_phase_q <= 1'b0;
			cfg_valid_o <= 1'b0;
		end else if (sleep) begin
			// Sleep overrides every state; a loaded image survives it.
			cnt_q <= 11'h000;
			in_phase_q <= 1'b0;
			error_q <= 1'b0;
			extra_q <= 1'b0;
			if (cfg_valid_o) begin
				state_q <= ST_START;
			end else if (state_q != ST_STAB) begin
				state_q <= ST_CLEAR;
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			mode_q <= mode_d;
			extra_q <= extra_d;
			error_q <= error_d;
			in_phase_q <= in_phase_d;
			if (state_d == ST_CLEAR) begin
				cfg_valid_o <= 1'b0;
			end else if (state_d == ST_START) begin
				cfg_valid_o <= 1'b1;
			end
		end
	end

	// Load clock generation, edge detection and data reception.
	always @(posedge sys_clk_i) begin
		if (sys_rst_i || sleep || state_q != ST_LOAD) begin
			gen_clk_q <= 1'b0;
			div_q <= 3'h0;
			lclk_prev_q <= 1'b0;
			sh_q <= 8'h00;
			bitcnt_q <= 3'h0;
			bytes_q <= 8'h00;
			fwd1_q <= 1'b0;
			fwd0_q <= 1'b0;
			share_done_q <= 1'b0;
			cfg_word_o <= 8'h00;
			cfg_word_valid_o <= 1'b0;
		end else begin
			lclk_prev_q <= sy[`CPS_SY_LCLK];
			cfg_word_valid_o <= 1'b0;
			if (master && !error_q) begin
				div_q <= div_q + 3'h1;
				if (div_q == `CPS_DIV_HALF) begin
					gen_clk_q <= ~gen_clk_q;
				end
			end
			if (lclk_rise && !share_done_q) begin
				if (mode_q == `CPS_MODE_BYTE) begin
					if (sy[`CPS_SY_CHSEL]) begin
						cfg_word_o <= sy[`CPS_SY_BUS +: 8];
						cfg_word_valid_o <= 1'b1;
					end
				end else begin
					sh_q <= {sh_q[6:0], sy[`CPS_SY_SDIN]};
					bitcnt_q <= bitcnt_q + 3'h1;
					if (bitcnt_q == 3'h7) begin
						cfg_word_o <= {sh_q[6:0], sy[`CPS_SY_SDIN]};
						cfg_word_valid_o <= 1'b1;
					end
				end
			end
			if (cfg_word_valid_o) begin
				bytes_q <= bytes_q + 8'h01;
				if (last_byte) begin
					share_done_q <= 1'b1;
				end
			end
			// Two stages give one and a half periods from capture to fall.
			if (lclk_rise) begin
				fwd1_q <= sy[`CPS_SY_SDIN];
				fwd0_q <= fwd1_q;
			end
		end
	end

	// Pin drive derived from the state; all outputs are registered.
	always @(posedge sys_clk_i) begin
		if (sys_rst_i || sleep) begin
			// Asleep or in reset all user I/O is off.
			user_in_en_o <= 1'b0;
			user_out_en_o <= 1'b0;
			user_pullup_o <= 1'b1;
			cfg_active_high_flag_o <= 1'b1;
			cfg_active_low_flag_o <= 1'b0;
			clear_wait_oe_o <= 1'b1;
			load_complete_oe_o <= 1'b1;
			load_clock_o <= 1'b0;
			load_clock_oe_o <= 1'b0;
			ser_out_o <= 1'b0;
			cfg_mem_clear_o <= 1'b0;
		end else begin
			user_in_en_o <= (state_q == ST_USER) ||
				(state_q == ST_START && in_phase_q);
			user_out_en_o <= (state_q == ST_USER);
			user_pullup_o <= (state_q != ST_USER);
			if (state_q == ST_USER) begin
				cfg_active_high_flag_o <= user_flag_hi_i;
				cfg_active_low_flag_o <= user_flag_lo_i;
			end else begin
				cfg_active_high_flag_o <= 1'b1;
				cfg_active_low_flag_o <= 1'b0;
			end
			clear_wait_oe_o <= (state_q == ST_STAB) ||
				(state_q == ST_CLEAR) ||
				(state_q == ST_LOAD && error_q);
			load_complete_oe_o <= (state_q != ST_START) &&
				(state_q != ST_USER);
			cfg_mem_clear_o <= (state_q == ST_CLEAR);
			load_clock_o <= gen_clk_q;
			load_clock_oe_o <= master && (state_q == ST_LOAD);
			// Byte mode keeps the next device enabled once this share is in.
			if (mode_q == `CPS_MODE_BYTE) begin
				ser_out_o <= share_done_q || (state_q == ST_START) ||
					(state_q == ST_USER);
			end else if (state_q != ST_LOAD) begin
				ser_out_o <= 1'b0;
			end else if (lclk_fall) begin
				ser_out_o <= fwd0_q;
			end
		end
	end

endmodule // cps_top

`default_nettype wire

// ===== tb/cps_top_asserts.sv
// Checker for cps_top: flags, wake order, sleep, clear and wait.
// Assumes it is bound to cps_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cps_top_asserts (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Pins watched.
	input wire logic sleep_request_n_i,
	input wire logic clear_wait_i,
	input wire logic clear_wait_oe_o,
	input wire logic load_complete_oe_o,
	input wire logic load_clock_oe_o,
	input wire logic cfg_active_high_flag_o,
	input wire logic cfg_active_low_flag_o,
	input wire logic user_in_en_o,
	input wire logic user_out_en_o,
	input wire logic cfg_word_valid_o,
	input wire logic cfg_mem_clear_o,
	input wire logic cfg_valid_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Counted on the wire, so an outside hold restarts the wait.
	logic [15:0] high_q;
	always @(posedge sys_clk_i) begin
		if (sys_rst_i || !clear_wait_i)
			high_q <= 16'h0000;
		else if (high_q != 16'hffff)
			high_q <= high_q + 16'h0001;
	end
	sequence s_asleep;
		!sleep_request_n_i [*6];
	endsequence
	a_hi_flag: assert property (
		!user_out_en_o |-> cfg_active_high_flag_o)
		else $error("high flag dropped early");
	a_lo_flag: assert property (
		!user_out_en_o |-> !cfg_active_low_flag_o)
		else $error("low flag rose early");
	a_out_after_in: assert property (
		user_out_en_o |-> user_in_en_o && $past(user_in_en_o))
		else $error("outputs before inputs");
	a_sleep_off: assert property (
		s_asleep |-> !user_in_en_o && !user_out_en_o && load_complete_oe_o)
		else $error("pins live while asleep");
	a_cfg_kept: assert property (
		s_asleep |-> $stable(cfg_valid_o))
		else $error("config lost in sleep");
	a_clear_pulls: assert property (
		cfg_mem_clear_o |-> clear_wait_oe_o)
		else $error("clear without pull");
	a_word_in_load: assert property (
		cfg_word_valid_o |-> !clear_wait_oe_o ##1 !cfg_word_valid_o)
		else $error("bad word pulse");
	a_done_release: assert property (
		user_out_en_o |-> !load_complete_oe_o)
		else $error("done held in user mode");
	a_master_wait: assert property (
		$rose(load_clock_oe_o) |->
		high_q >= 16'h04b0 && high_q <= 16'h2ee0)
		else $error("master wait out of range");
endmodule // cps_top_asserts
bind cps_top cps_top_asserts u_chk (.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i), .sleep_request_n_i(sleep_request_n_i),
	.clear_wait_i(clear_wait_i), .clear_wait_oe_o(clear_wait_oe_o),
	.load_complete_oe_o(load_complete_oe_o),
	.load_clock_oe_o(load_clock_oe_o),
	.cfg_active_high_flag_o(cfg_active_high_flag_o),
	.cfg_active_low_flag_o(cfg_active_low_flag_o),
	.user_in_en_o(user_in_en_o), .user_out_en_o(user_out_en_o),
	.cfg_word_valid_o(cfg_word_valid_o),
	.cfg_mem_clear_o(cfg_mem_clear_o), .cfg_valid_o(cfg_valid_o));
`default_nettype wire

// ===== tb/cps_src.sv
// Configuration source: one byte per request, serial MSB first or one
// byte-wide beat, on its own 200 ns clock that rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module cps_src (
	// Request.
	input wire logic go_i,
	input wire logic byte_mode_i,
	input wire logic [7:0] byte_i,
	input wire logic ser_out_i,
	// Pins and observation.
	output var logic lclk_o = 1'h0,
	output var logic sdat_o = 1'h0,
	output var logic [7:0] bus_o = 8'h00,
	output var logic busy_o = 1'h0,
	output var logic [7:0] seen_o = 8'h00
);
	always @(posedge go_i) begin
		busy_o = 1'h1;
		#7;
		if (byte_mode_i) begin
			bus_o = byte_i;
			#100 lclk_o = 1'h1;
			#100 lclk_o = 1'h0;
			bus_o = ~byte_i;
		end else begin
			for (int i = 7; i >= 0; i--) begin
				sdat_o = byte_i[i];
				#100 lclk_o = 1'h1;
				seen_o = {seen_o[6:0], ser_out_i};
				#100 lclk_o = 1'h0;
			end
			// A released line must not keep showing the last bit.
			sdat_o = ~sdat_o;
		end
		busy_o = 1'h0;
	end
endmodule // cps_src
`default_nettype wire

// ===== tb/cps_top_test.sv
// Testbench for cps_top: serial and byte loads, master clock, sleep, wake,
// reconfigure, wait hold and data error. Uses cps_src and the checker.
`timescale 1ns/1ps
`default_nettype none
module cps_top_test;
	logic clk = 0, rst = 1, sleep_n = 1, recfg_n = 1, go = 0, hold = 1;
	logic err = 0, chs = 0, ufh = 0, ufl = 1, bmode = 0;
	logic [1:0] mode = 2'h3;
	logic [7:0] tx = 8'h00, prev, last_w = 8'h00, seen, w, bus;
	logic cw_oe, lc_oe, lc_o, cp_oe, dout, hi, lo, ien, oen, pu, cv, wv;
	logic lclk, sdat, busy;
	int num_errors = 0, comparisons = 0, nw = 0, k;
	wire cw = !(cw_oe | hold);
	wire lc = lc_oe ? lc_o : lclk;
	cps_top dut (.sys_clk_i(clk), .sys_rst_i(rst),
		.sleep_request_n_i(sleep_n), .reconfig_n_i(recfg_n),
		.load_mode_select_i(mode), .clear_wait_i(cw), .clear_wait_o(),
		.clear_wait_oe_o(cw_oe), .load_complete_i(!cp_oe),
		.load_complete_o(), .load_complete_oe_o(cp_oe),
		.load_clock_i(lc), .load_clock_o(lc_o), .load_clock_oe_o(lc_oe),
		.ser_data_i(sdat), .chain_select_i(chs), .byte_load_bus_i(bus),
		.ser_out_o(dout), .cfg_active_high_flag_o(hi),
		.cfg_active_low_flag_o(lo), .user_flag_hi_i(ufh),
		.user_flag_lo_i(ufl), .user_in_en_o(ien), .user_out_en_o(oen),
		.user_pullup_o(pu), .cfg_error_i(err), .cfg_word_o(w),
		.cfg_word_valid_o(wv), .cfg_mem_clear_o(), .cfg_valid_o(cv));
	cps_src src (.go_i(go), .byte_mode_i(bmode), .byte_i(tx),
		.ser_out_i(dout), .lclk_o(lclk), .sdat_o(sdat), .bus_o(bus),
		.busy_o(busy), .seen_o(seen));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wv === 1'h1) begin
			last_w <= w;
			nw <= nw + 1;
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task send(input logic [7:0] b);
		tx <= b;
		go <= 1;
		cyc(2);
		for (k = 0; k < 100 && busy; k++) cyc(1);
		go <= 0;
		cyc(4);
	endtask
	// The forward lags the input by two rising edges of the load clock.
	function automatic logic [7:0] fwd_exp(input logic [7:0] p,
			input logic [7:0] c);
		return {p[1:0], c[7:2]};
	endfunction
	task load(input int n, input logic take);
		int c;
		for (int i = 0; i < n; i++) begin
			c = nw;
			prev = tx;
			send(8'($urandom));
			chk("words", 8'(c + take), 8'(nw));
			if (take)
				chk("word", tx, last_w);
			if (take && !bmode && i > 0)
				chk("fwd", fwd_exp(prev, tx), seen);
		end
	endtask
	task reload(input logic [1:0] m);
		mode <= m;
		recfg_n <= 0;
		cyc(5);
		recfg_n <= 1;
		chk("valid", 8'h00, 8'(cv));
		cyc(17);
		chk("cw_oe", 8'h01, 8'(cw_oe));
		for (k = 0; k < 200 && cw_oe; k++) cyc(1);
		cyc(4);
	endtask
	initial begin
		k = $urandom(32'h0ace_8d4d);
		cyc(10);
		rst <= 0;
		chk("hi", 8'h01, 8'(hi));
		chk("lo", 8'h00, 8'(lo));
		chk("pullup", 8'h01, 8'(pu));
		ufh <= 1'($urandom);
		ufl <= 1'($urandom);
		cyc(150);
		chk("cw_oe", 8'h00, 8'(cw_oe));
		load(1, 0);
		hold <= 0;
		cyc(8);
		load(16, 1);
		for (k = 0; k < 40 && !oen; k++) cyc(1);
		chk("out_en", 8'h01, 8'(oen));
		chk("done_oe", 8'h00, 8'(cp_oe));
		chk("pullup", 8'h00, 8'(pu));
		chk("hi", 8'(ufh), 8'(hi));
		chk("lo", 8'(ufl), 8'(lo));
		load(1, 0);
		sleep_n <= 0;
		cyc(8);
		chk("in_en", 8'h00, 8'(ien));
		chk("valid", 8'h01, 8'(cv));
		sleep_n <= 1;
		for (k = 0; k < 20 && !ien; k++) cyc(1);
		chk("out_en", 8'h00, 8'(oen));
		cyc(1);
		chk("out_en", 8'h01, 8'(oen));
		reload(2'h0);
		for (k = 0; k < 1400 && !lc_oe; k++) cyc(1);
		chk("clk_oe", 8'h01, 8'(lc_oe));
		// The generated clock must flip every eight cycles while loading.
		prev = 8'(lc_o);
		cyc(8);
		chk("clk_out", 8'(!prev[0]), 8'(lc_o));
		err <= 1;
		cyc(6);
		chk("cw_oe", 8'h01, 8'(cw_oe));
		err <= 0;
		bmode <= 1;
		reload(2'h2);
		chk("dout", 8'h00, 8'(dout));
		load(2, 0);
		sleep_n <= 0;
		cyc(8);
		sleep_n <= 1;
		cyc(8);
		chk("cw_oe", 8'h01, 8'(cw_oe));
		for (k = 0; k < 200 && cw_oe; k++) cyc(1);
		chs <= 1;
		cyc(4);
		load(16, 1);
		cyc(4);
		chk("dout", 8'h01, 8'(dout));
		final_report;
	end
	// The run needs about three thousand cycles; this leaves wide margin.
	initial begin
		cyc(20000);
		num_errors++;
		final_report;
	end
endmodule // cps_top_test
`default_nettype wire
